/* File: bench/achp_dac_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Stands in for the converter side that takes finished playback samples.
module achp_dac_model (
  input  wire logic        clk_in,
  input  wire logic        stall_in,
  input  wire logic        valid_in,
  input  wire logic [31:0] data_in,
  output logic             ready_out,
  output logic [31:0]      last_q,
  output logic [7:0]       count_q
);
  // Stalling lets the bench fill the sample FIFO before anything drains.
  assign ready_out = !stall_in;
  initial count_q = 8'h00;
  always @(posedge clk_in) begin
    if (valid_in && ready_out) begin
      last_q  <= data_in;
      count_q <= count_q + 8'h01;
    end
  end
endmodule // achp_dac_model
`default_nettype wire

/* File: bench/audio_codec_host_register_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
module audio_codec_host_register_port_test;
  import achp_pkg::*;
  logic        clk, srst, rd, wr, busy, pirq, cirq, stall, pv, irq, pda, cda, calb, playback_ready_bit;
  logic [2:0]  pls;
  logic [1:0]  addr, pm;
  logic [7:0]  wd, rdat, r, b, clo, cnt, plo, phi, chi;
  logic [31:0] cs, ps, last;
  logic [31:0] wq[5];
  int          miscompares = 0, num_checks = 0, cyc = 0;
  int          lens[4] = '{0, 136, 40, 168};
  integer      seed = 32'h8c27;
  achp_port DUT (.SYS_CLK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr), .RD_IN(rd), .WR_IN(wr), .WDATA_IN(wd),
    .INIT_BUSY_IN(busy), .POWER_MGMT_IN(pm), .CAP_SAMPLE_VALID_IN(pls[0]), .CAP_SAMPLE_IN(cs),
    .SAMPLE_TICK_IN(pls[1]), .PLAY_SAMPLE_READY_IN(playback_ready_bit), .CODEC_IRQ_SET_IN(pls[2]), .PLAY_IRQ_IN(pirq),
    .CAP_IRQ_IN(cirq), .RDATA_OUT(rdat), .PLAY_SAMPLE_VALID_OUT(pv), .PLAY_SAMPLE_OUT(ps), .IRQ_OUT(irq),
    .PLAY_DMA_ALLOW_OUT(pda), .CAP_DMA_ALLOW_OUT(cda), .CAL_BUSY_OUT(calb), .PLAY_COUNT_HI_OUT(phi),
    .PLAY_COUNT_LO_OUT(plo), .CAP_COUNT_HI_OUT(chi), .CAP_COUNT_LO_OUT(clo));
  achp_dac_model PEER (.clk_in(clk), .stall_in(stall), .valid_in(pv), .data_in(ps), .ready_out(playback_ready_bit),
    .last_q(last), .count_q(cnt));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Prints the counts and the verdict, then stops the run.
  task automatic finish_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One host access; the strobe drops on the edge that takes it, so calls never collide.
  task automatic acc(input logic [1:0] a, input logic w_en, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= w_en;
    rd <= !w_en;
    @(negedge clk);
    r = rdat;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdc(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e, input string s);
    acc(a, 1'b0, 8'h00);
    chk(r & m, e, s);
  endtask
  task automatic wrx(input logic [7:0] f, input logic [4:0] i, input logic [7:0] d);
    acc(OFS_INDEX, 1'b1, f | {3'h0, i});
    acc(OFS_WINDOW, 1'b1, d);
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    pls[k] <= 1'b1;
    @(posedge clk);
    pls <= 3'h0;
  endtask
  // A hang is cut short well beyond the longest expected run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    {rd, wr, busy, pls, pirq, cirq, stall} = '0;
    addr = 2'h0; pm = 2'h0; wd = 8'h00; cs = 32'h0; srst = 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdc(OFS_INDEX, 8'hEF, IDX_RESET_VAL, "index reset");
    acc(OFS_INDEX, 1'b1, {3'h0, IND_MODE});
    rdc(OFS_WINDOW, 8'hFF, MODE_RESET_VAL, "mode reset");
    for (int k = 0; k < 2; k++) begin
      busy <= (k == 0);
      pm <= k[1:0];
      acc(OFS_INDEX, 1'b1, 8'h05);
      for (int a = 0; a < 4; a++) rdc(a[1:0], 8'hFF, a == 2 ? 8'hCE : BUSY_READ_VAL, "busy read");
      busy <= 1'b0;
      pm <= 2'h0;
      rdc(OFS_INDEX, 8'hEF, 8'h0C, "busy write");
    end
    $display("busy test done");
    wrx(8'h00, IND_FMT, 8'hDF);
    rdc(OFS_WINDOW, 8'hFF, 8'h00, "fmt locked");
    wrx(8'h40, IND_FMT, 8'hDF);
    rdc(OFS_WINDOW, 8'hFF, 8'h5F, "fmt open");
    for (int c = 0; c < 4; c++) begin
      wrx(8'h40, IND_CFG, {3'h0, c[1:0], 3'h0});
      acc(OFS_INDEX, 1'b1, {3'h0, IND_CFG});
      repeat (2) @(posedge clk);
      for (int t = 0; t <= lens[c]; t++) begin
        @(negedge clk);
        chk(calb, t < lens[c], "cal busy");
        pulse(1);
      end
    end
    wrx(8'h00, IND_CFG, 8'hFF);
    rdc(OFS_WINDOW, 8'hFF, 8'h1B, "cfg locked");
    b = $random(seed);
    wrx(8'h00, IND_PLB, b);
    @(negedge clk);
    chk({phi, chi, plo, clo}, {16'h0000, b, b}, "legacy count");
    $display("register test done");
    stall <= 1'b1;
    for (int s = 0; s < 5; s++) begin
      wq[s] = $random(seed);
      for (int k = 0; k < 5; k++) begin
        if (k < 4) rdc(OFS_STATUS, 8'h0E, {4'h0, k[0], !k[1], 2'b10}, "byte bits");
        acc(OFS_PIO, 1'b1, k < 4 ? wq[s][8*k +: 8] : ~wq[s][7:0]);
      end
      rdc(OFS_STATUS, 8'h02, 8'h00, "filled");
    end
    rdc(OFS_STATUS, 8'h02, 8'h00, "fifo full");
    chk(cnt, 8'h00, "stalled");
    stall <= 1'b0;
    repeat (8) @(posedge clk);
    chk({cnt, last}, {8'h05, wq[4]}, "drained");
    rdc(OFS_STATUS, 8'h02, 8'h02, "last fill");
    repeat (8) @(posedge clk);
    chk({cnt, last}, {8'h05, wq[4]}, "held sample");
    $display("playback test done");
    pulse(1);
    rdc(OFS_STATUS, 8'h10, 8'h10, "underrun");
    wrx(8'h20, IND_PIN, 8'h02);
    pirq <= 1'b1;
    pulse(2);
    @(negedge clk);
    chk({irq, pda, cda}, 3'b101, "irq on");
    acc(OFS_STATUS, 1'b1, 8'hFF);
    rdc(OFS_STATUS, 8'h03, 8'h02, "int clear");
    chk({irq, pda}, 2'b01, "irq off");
    $display("interrupt test done");
    cs <= $random(seed);
    pulse(0);
    rdc(OFS_STATUS, 8'hE0, 8'h60, "cap ready");
    for (int k = 0; k < 5; k++) rdc(OFS_PIO, 8'hFF, cs[8*(k > 3 ? 3 : k) +: 8], "cap byte");
    $display("capture test done");
    wrx(8'h40, IND_CFG, 8'h03);
    wrx(8'h40, IND_MODE, MODE_RESET_VAL | 8'h40);
    b = $random(seed);
    wrx(8'h00, IND_CLB, b);
    rdc(OFS_INDEX, 8'h1F, 8'h1F, "index bit four");
    rdc(OFS_WINDOW, 8'hFF, b, "ext reg");
    chk(clo, b, "cap count");
    wrx(8'h00, IND_CAPFMT, 8'hF0);
    rdc(OFS_WINDOW, 8'hF0, 8'h00, "capfmt locked");
    $display("extended test done");
    finish_test();
  end
endmodule // audio_codec_host_register_port_test
`default_nettype wire

/* File: core/achp_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module achp_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic clk_in,
  input  wire logic srst_in,
  achp_fifo_if.snk  wr,
  achp_fifo_if.src  rd
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage array.
  logic [AW-1:0]    wptr_q, wptr_d; // Write pointer.
  logic [AW-1:0]    rptr_q, rptr_d; // Read pointer.
  logic [AW:0]      cnt_q, cnt_d;   // Occupancy.
  logic             push, pop;      // Handshakes of this cycle.

  // Full and empty come straight from the occupancy count.
  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem_q[rptr_q];
  assign push = wr.valid && wr.ready;
  assign pop  = rd.valid && rd.ready;

  // Pointer and count updates.
  always_comb begin
    wptr_d = push ? wptr_q + AW'(1) : wptr_q;
    rptr_d = pop ? rptr_q + AW'(1) : rptr_q;
    cnt_d  = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Registers only; memory has no reset since it is qualified by the count.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q  <= cnt_d;
    end
    if (push) begin
      mem_q[wptr_q] <= wr.data;
    end
  end
endmodule : achp_fifo
`default_nettype wire

/* File: core/achp_fifo_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Valid/ready word stream between the port logic and its sample FIFO.
interface achp_fifo_if #(parameter int unsigned W = 32);
  logic         valid; // Producer offers a word.
  logic         ready; // Consumer accepts a word.
  logic [W-1:0] data;  // Word carried.
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : achp_fifo_if
`default_nettype wire

/* File: core/achp_pkg.sv */
package achp_pkg;
  // Direct register offsets within the four-byte window.
  localparam logic [1:0] OFS_INDEX  = 2'h0;
  localparam logic [1:0] OFS_WINDOW = 2'h1;
  localparam logic [1:0] OFS_STATUS = 2'h2;
  localparam logic [1:0] OFS_PIO    = 2'h3;
  // Index pointer layout and fixed read values.
  localparam int unsigned IDX_MCE_BIT = 6;
  localparam int unsigned IDX_TRD_BIT = 5;
  localparam logic [7:0] IDX_RESET_VAL = 8'h40;
  localparam logic [7:0] BUSY_READ_VAL = 8'h80;
  // Indirect register indices that the port logic itself interprets.
  localparam logic [4:0] IND_FMT    = 5'h08;
  localparam logic [4:0] IND_CFG    = 5'h09;
  localparam logic [4:0] IND_PIN    = 5'h0A;
  localparam logic [4:0] IND_MODE   = 5'h0C;
  localparam logic [4:0] IND_PUB    = 5'h0E;
  localparam logic [4:0] IND_PLB    = 5'h0F;
  localparam logic [4:0] IND_ALT1   = 5'h10;
  localparam logic [4:0] IND_AFS    = 5'h18;
  localparam logic [4:0] IND_CAPFMT = 5'h1C;
  localparam logic [4:0] IND_CUB    = 5'h1E;
  localparam logic [4:0] IND_CLB    = 5'h1F;
  // Write masks for protected fields.
  localparam logic [7:0] MASK_HI4   = 8'hF0;
  localparam logic [7:0] MASK_LO4   = 8'h0F;
  localparam logic [7:0] MASK_CFG6  = 8'hFC;
  localparam logic [7:0] MASK_SERIAL = 8'h0E;
  localparam logic [7:0] MASK_FORMAT_BIT_HIGH  = 8'h80;
  localparam logic [7:0] MASK_DTM   = 8'h04;
  // Bit positions inside indirect registers.
  localparam int unsigned ALT1_CAPTURE_FORMAT_CHANGE_FLAG_BIT = 5;
  localparam int unsigned ALT1_PLAYBACK_FORMAT_CHANGE_FLAG_BIT = 4;
  localparam int unsigned CFG_PEN_BIT = 0;
  localparam int unsigned CFG_CEN_BIT = 1;
  localparam int unsigned PIN_IEN_BIT = 1;
  localparam int unsigned MODE_EXT_BIT = 6;
  localparam logic [7:0] MODE_RESET_VAL = 8'h8A;
  localparam int unsigned AFS_CO_BIT = 2;
  localparam int unsigned AFS_PU_BIT = 0;
  // Format codes (FORMAT_BIT_HIGH, FORMAT_BIT_LOW, C/L).
  localparam logic [2:0] FMT_U8 = 3'h0;
  localparam logic [2:0] FMT_ULAW = 3'h1;
  localparam logic [2:0] FMT_S16LE = 3'h2;
  localparam logic [2:0] FMT_ALAW = 3'h3;
  localparam logic [2:0] FMT_ADPCM = 3'h5;
  localparam logic [2:0] FMT_S16BE = 3'h6;
  // Calibration lengths in sample periods, indexed by the calibration code.
  localparam logic [7:0] CAL_LEN_CONV = 8'd136;
  localparam logic [7:0] CAL_LEN_DAC = 8'd40;
  localparam logic [7:0] CAL_LEN_FULL = 8'd168;
  // Sample forwarding FIFO shape.
  localparam int unsigned FIFO_WIDTH = 32;
  localparam int unsigned FIFO_DEPTH = 4;
  // Byte tracker state.
  typedef enum logic [1:0] {BYTE_0, BYTE_1, BYTE_2, BYTE_3} achp_byte_t;
endpackage : achp_pkg

/* File: core/achp_port.sv */
// Overview of operation
// R1 - Rate/format halves writable under change flags.
// R2 - Config upper six need mode change.
// R3 - Serial bits need mode change.
// R4 - Capture format upper four need flags.
// R5 - Extended-only bits and registers 16-31.
// R6 - Legacy mode shares playback base counts.
// R7 - Four-bit level codes map linearly.
// R8 - Six-bit attenuation 1.5 dB per step.
// R9 - Five-bit mixer gain +12 dB start.
// R10 - Rate divide plus clock base select.
// R11 - Three format bits select data format.
// R12 - Index selects register, resets to 010x0000.
// R13 - Transfer disable stalls DMA during interrupt.
// R14 - Index reads 80h while busy.
// R15 - Window and data port read 80h busy.
// R16 - Status write clears interrupt bit.
// R17 - Ready bits show port data state.
// R18 - Side and half bits name byte.
// R19 - Sample error on overrun or underrun.
// R20 - Data port writes playback, reads capture.
// R21 - Capture reads advance tracker, hold last.
// R22 - Playback writes advance, extra ignored.
// R23 - Host writes index before window access.
// R24 - Starts legacy; mode bit enables extended.
// R25 - Mode change fall starts calibration.
// R26 - Status write only clears interrupt.
// R27 - Host reads status before data access.
`timescale 1ns/1ps
`default_nettype none
module achp_port
  import achp_pkg::*;
(
  input  wire logic       SYS_CLK_IN,          // System clock, 25 MHz.
  input  wire logic       SRST_IN,             // Synchronous reset, active high.
  input  wire logic [1:0] ADDR_IN,             // Offset from the codec base.
  input  wire logic       RD_IN,               // Read strobe, one cycle.
  input  wire logic       WR_IN,               // Write strobe, one cycle.
  input  wire logic [7:0] WDATA_IN,            // Write data.
  input  wire logic       INIT_BUSY_IN,        // Codec initialising.
  input  wire logic [1:0] POWER_MGMT_IN,       // Power management code.
  input  wire logic       CAP_SAMPLE_VALID_IN, // New capture sample, one cycle.
  input  wire logic [31:0] CAP_SAMPLE_IN,      // Capture sample bytes, first byte low.
  input  wire logic       SAMPLE_TICK_IN,      // One sample period, one cycle.
  input  wire logic       PLAY_SAMPLE_READY_IN,// DAC side takes a sample.
  input  wire logic       CODEC_IRQ_SET_IN,    // Internal interrupt event.
  input  wire logic       PLAY_IRQ_IN,         // Playback interrupt source.
  input  wire logic       CAP_IRQ_IN,          // Capture interrupt source.
  output logic [7:0]      RDATA_OUT,           // Read data.
  output logic            PLAY_SAMPLE_VALID_OUT, // Sample offered to DACs.
  output logic [31:0]     PLAY_SAMPLE_OUT,     // Sample to DACs.
  output logic            IRQ_OUT,             // Interrupt request pin level.
  output logic            PLAY_DMA_ALLOW_OUT,  // Playback DMA may run.
  output logic            CAP_DMA_ALLOW_OUT,   // Capture DMA may run.
  output logic            CAL_BUSY_OUT,        // Calibration running.
  output logic [7:0]      PLAY_COUNT_HI_OUT,   // Base count used by playback.
  output logic [7:0]      PLAY_COUNT_LO_OUT,
  output logic [7:0]      CAP_COUNT_HI_OUT,    // Base count used by capture.
  output logic [7:0]      CAP_COUNT_LO_OUT
);
  logic [7:0]  ind_q [32];           // Indirect register file.
  logic [7:0]  ind_d [32];
  logic [4:0]  idx_q, idx_d;         // Low index bits.
  logic        mce_q, mce_d;         // Mode change flag.
  logic        trd_q, trd_d;         // Transfer disable flag.
  logic        int_q, int_d;         // Interrupt status.
  logic        ser_q, ser_d;         // Sample error.
  logic [7:0]  cap_data_q, cap_data_d; // Capture byte shown on the port.
  logic [31:0] cap_smp_q, cap_smp_d; // Capture sample held.
  logic        capture_ready_bit_q, capture_ready_bit_d;       // Capture byte fresh.
  achp_byte_t  cbyte_q, cbyte_d;     // Capture byte tracker.
  logic        crearm_q, crearm_d;   // Status read seen since last sample load.
  logic [31:0] pl_smp_q, pl_smp_d;   // Playback sample being assembled.
  achp_byte_t  pbyte_q, pbyte_d;     // Playback byte tracker.
  logic        pfull_q, pfull_d;     // All playback bytes written.
  logic        prearm_q, prearm_d;   // Status read seen after fill.
  logic [7:0]  cal_q, cal_d;         // Calibration sample countdown.
  logic        busy;                 // Init or software power-down.
  logic        ext;                  // Extended mode.
  logic [2:0]  pfmt, cfmt;           // Effective formats.
  logic [1:0]  plast, clast;         // Last byte index of a sample.
  logic        stat_rd, pio_rd, pio_wr, win_wr;
  logic        push_ok;              // FIFO accepts the playback sample.
  logic [7:0]  wmask;                // Writable bits of the indexed register.

  achp_fifo_if #(.W(FIFO_WIDTH)) fin ();
  achp_fifo_if #(.W(FIFO_WIDTH)) fout ();

  // Playback samples queue toward the DACs; a stalled DAC side backs up here.
  achp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in (SYS_CLK_IN),
    .srst_in(SRST_IN),
    .wr     (fin),
    .rd     (fout)
  );
  assign fout.ready = PLAY_SAMPLE_READY_IN;
  assign PLAY_SAMPLE_VALID_OUT = fout.valid;
  assign PLAY_SAMPLE_OUT = fout.data;

  // Busy states block index, window and data port writes and force 80h reads there; status reads and writes still work.
  assign busy = INIT_BUSY_IN || (POWER_MGMT_IN == 2'h1);
  // R24 mode select
  assign ext = ind_q[IND_MODE][MODE_EXT_BIT];
  assign stat_rd = RD_IN && (ADDR_IN == OFS_STATUS);
  // R20 port direction split
  assign pio_rd = RD_IN && (ADDR_IN == OFS_PIO) && !busy;
  assign pio_wr = WR_IN && (ADDR_IN == OFS_PIO) && !busy;
  assign win_wr = WR_IN && (ADDR_IN == OFS_WINDOW) && !busy;

  // Effective formats; legacy mode forces the top format bit low and shares one format.
  // R5 top format bit
  // R11 format decode
  assign pfmt = {ext & ind_q[IND_FMT][7], ind_q[IND_FMT][6:5]};
  assign cfmt = ext ? ind_q[IND_CAPFMT][7:5] : pfmt;

  // Last byte of one sample from format and stereo bit; ADPCM runs four bytes.
  function automatic logic [1:0] last_byte(input logic [2:0] f, input logic st);
    logic wide;
    wide = (f == FMT_S16LE) || (f == FMT_S16BE);
    if (f == FMT_ADPCM) begin
      last_byte = 2'h3;
    end else begin
      // Sixteen-bit stereo runs four bytes, so both bits are set then.
      last_byte = {wide & st, wide | st};
    end
  endfunction
  assign plast = last_byte(pfmt, ind_q[IND_FMT][4]);
  assign clast = last_byte(cfmt, ext ? ind_q[IND_CAPFMT][4] : ind_q[IND_FMT][4]);

  // Side bit: 1 for left, mono, or ADPCM bytes one and two.
  function automatic logic side_bit(input logic [2:0] f, input logic st, input achp_byte_t b);
    logic wide;
    wide = (f == FMT_S16LE) || (f == FMT_S16BE);
    if (f == FMT_ADPCM || wide) begin
      side_bit = !st || (b < BYTE_2) || (f == FMT_ADPCM && b < BYTE_2);
      if (f == FMT_ADPCM) side_bit = (b < BYTE_2);
    end else begin
      side_bit = !st || (b == BYTE_0);
    end
  endfunction

  // Half bit: 1 for upper, any 8-bit format, or ADPCM bytes two and four.
  function automatic logic half_bit(input logic [2:0] f, input achp_byte_t b);
    if ((f == FMT_S16LE) || (f == FMT_S16BE) || (f == FMT_ADPCM)) begin
      half_bit = b[0];
    end else begin
      half_bit = 1'b1;
    end
  endfunction

  // Writable mask for the indexed register under the protection flags.
  always_comb begin
    wmask = 8'hFF;
    unique case (idx_q)
      // R1 rate/format protection
      // R5 legacy top format bit
      IND_FMT: wmask = ((mce_q ? MASK_LO4 : 8'h00)
                     | ((mce_q || ind_q[IND_ALT1][ALT1_PLAYBACK_FORMAT_CHANGE_FLAG_BIT]) ? MASK_HI4 : 8'h00))
                     & (ext ? 8'hFF : ~MASK_FORMAT_BIT_HIGH);
      // R2 config protection
      IND_CFG: wmask = mce_q ? 8'hFF : ~MASK_CFG6;
      // R3 serial bit protection
      IND_ALT1: wmask = mce_q ? 8'hFF : ~MASK_SERIAL;
      // R4 capture format protection
      IND_CAPFMT: wmask = (mce_q || ind_q[IND_ALT1][ALT1_CAPTURE_FORMAT_CHANGE_FLAG_BIT]) ? MASK_HI4 : 8'h00;
      // R5 extended-only test bit
      IND_PIN: wmask = ext ? 8'hFF : ~MASK_DTM;
      default: wmask = 8'hFF;
    endcase
  end

  // Next state of the register file and PIO machinery.
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      ind_d[i] = ind_q[i];
    end
    idx_d = idx_q;
    mce_d = mce_q;
    trd_d = trd_q;
    int_d = int_q;
    ser_d = ser_q;
    cap_data_d = cap_data_q;
    cap_smp_d = cap_smp_q;
    capture_ready_bit_d = capture_ready_bit_q;
    cbyte_d = cbyte_q;
    crearm_d = crearm_q;
    pl_smp_d = pl_smp_q;
    pbyte_d = pbyte_q;
    pfull_d = pfull_q;
    prearm_d = prearm_q;
    cal_d = cal_q;
    // R14 index write lock
    // R12 index pointer
    if (WR_IN && (ADDR_IN == OFS_INDEX) && !busy) begin
      idx_d = {ext & WDATA_IN[4], WDATA_IN[3:0]};
      mce_d = WDATA_IN[IDX_MCE_BIT];
      trd_d = WDATA_IN[IDX_TRD_BIT];
    end
    // Level and rate codes are stored as written; the converter side decodes them.
    // R7 level codes stored
    // R8 attenuation codes stored
    // R9 mixer gain stored
    // R10 rate codes stored
    // R5 window reaches upper registers only in extended mode
    // R15 window write lock
    if (win_wr && (ext || !idx_q[4])) begin
      ind_d[idx_q] = (ind_q[idx_q] & ~wmask) | (WDATA_IN & wmask);
    end
    // R25 calibration start
    if (mce_q && !mce_d) begin
      unique case (ind_q[IND_CFG][4:3])
        2'h1: cal_d = CAL_LEN_CONV;
        2'h2: cal_d = CAL_LEN_DAC;
        2'h3: cal_d = CAL_LEN_FULL;
        default: cal_d = 8'h00;
      endcase
    end else if (SAMPLE_TICK_IN && (cal_q != 8'h00)) begin
      cal_d = cal_q - 8'h01;
    end
    // R16 interrupt clear
    // R26 status write side effect
    if (CODEC_IRQ_SET_IN) begin
      int_d = 1'b1;
    end else if (WR_IN && (ADDR_IN == OFS_STATUS)) begin
      int_d = 1'b0;
    end
    // A status read arms the capture tracker, and arms the playback tracker only once its sample is full.
    if (stat_rd) begin
      crearm_d = 1'b1;
      if (pfull_q) prearm_d = 1'b1;
    end
    // R21 capture tracker advance and hold
    if (pio_rd) begin
      capture_ready_bit_d = 1'b0;
      if (cbyte_q != achp_byte_t'(clast)) begin
        cbyte_d = achp_byte_t'(cbyte_q + 2'h1);
        cap_data_d = cap_smp_q[8*(cbyte_q+2'h1) +: 8];
        capture_ready_bit_d = 1'b1;
      end
    end
    if (CAP_SAMPLE_VALID_IN && ind_q[IND_CFG][CFG_CEN_BIT]) begin
      // R19 capture overrun
      if (capture_ready_bit_q || cbyte_q != achp_byte_t'(clast)) begin
        ser_d = 1'b1;
        ind_d[IND_AFS][AFS_CO_BIT] = 1'b1;
      end
      if (crearm_q || stat_rd) begin
        cap_smp_d = CAP_SAMPLE_IN;
        cap_data_d = CAP_SAMPLE_IN[7:0];
        cbyte_d = BYTE_0;
        capture_ready_bit_d = 1'b1;
        crearm_d = 1'b0;
      end
    end
    // R22 playback tracker, extra bytes ignored
    if (pio_wr && !pfull_q) begin
      pl_smp_d[8*pbyte_q +: 8] = WDATA_IN;
      if (pbyte_q == achp_byte_t'(plast)) begin
        pfull_d = 1'b1;
      end else begin
        pbyte_d = achp_byte_t'(pbyte_q + 2'h1);
      end
    end
    // Sample handed to the FIFO once a status read follows the fill.
    if (push_ok) begin
      pfull_d = 1'b0;
      prearm_d = 1'b0;
      pbyte_d = BYTE_0;
    end
    // R19 playback underrun
    if (SAMPLE_TICK_IN && ind_q[IND_CFG][CFG_PEN_BIT] && !fout.valid) begin
      ser_d = 1'b1;
      ind_d[IND_AFS][AFS_PU_BIT] = 1'b1;
    end
  end

  assign fin.valid = prearm_q && pfull_q;
  assign fin.data = pl_smp_q;
  assign push_ok = fin.valid && fin.ready;

  // Register all state.
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      for (int i = 0; i < 32; i++) begin
        ind_q[i] <= 8'h00;
      end
      ind_q[IND_MODE] <= MODE_RESET_VAL;
      idx_q <= IDX_RESET_VAL[4:0];
      mce_q <= IDX_RESET_VAL[IDX_MCE_BIT];
      trd_q <= IDX_RESET_VAL[IDX_TRD_BIT];
      int_q <= 1'b0;
      ser_q <= 1'b0;
      cap_data_q <= 8'h00;
      cap_smp_q <= 32'h0000_0000;
      capture_ready_bit_q <= 1'b0;
      cbyte_q <= BYTE_0;
      crearm_q <= 1'b1;
      pl_smp_q <= 32'h0000_0000;
      pbyte_q <= BYTE_0;
      pfull_q <= 1'b0;
      prearm_q <= 1'b0;
      cal_q <= 8'h00;
    end else begin
      for (int i = 0; i < 32; i++) begin
        ind_q[i] <= ind_d[i];
      end
      idx_q <= idx_d;
      mce_q <= mce_d;
      trd_q <= trd_d;
      int_q <= int_d;
      ser_q <= ser_d;
      cap_data_q <= cap_data_d;
      cap_smp_q <= cap_smp_d;
      capture_ready_bit_q <= capture_ready_bit_d;
      cbyte_q <= cbyte_d;
      crearm_q <= crearm_d;
      pl_smp_q <= pl_smp_d;
      pbyte_q <= pbyte_d;
      pfull_q <= pfull_d;
      prearm_q <= prearm_d;
      cal_q <= cal_d;
    end
  end

  // Read multiplexer; data is combinational from registered state, sampled with RD_IN.
  always_comb begin
    RDATA_OUT = 8'h00;
    unique case (ADDR_IN)
      // R14 busy index read
      OFS_INDEX: RDATA_OUT = busy ? BUSY_READ_VAL : {INIT_BUSY_IN, mce_q, trd_q, idx_q};
      // R15 busy window read
      OFS_WINDOW: RDATA_OUT = busy ? BUSY_READ_VAL : ((ext || !idx_q[4]) ? ind_q[idx_q] : 8'h00);
      // R17 ready bits
      // R18 byte position bits
      OFS_STATUS: RDATA_OUT = {half_bit(cfmt, cbyte_q),
                               side_bit(cfmt, ext ? ind_q[IND_CAPFMT][4] : ind_q[IND_FMT][4], cbyte_q),
                               capture_ready_bit_q, ser_q,
                               half_bit(pfmt, pbyte_q),
                               side_bit(pfmt, ind_q[IND_FMT][4], pbyte_q),
                               !pfull_q, int_q};
      OFS_PIO: RDATA_OUT = busy ? BUSY_READ_VAL : cap_data_q;
      default: RDATA_OUT = 8'h00;
    endcase
  end

  // R16 interrupt pin gating
  assign IRQ_OUT = int_q && ind_q[IND_PIN][PIN_IEN_BIT];
  // R13 transfer disable stall
  assign PLAY_DMA_ALLOW_OUT = !(trd_q && int_q && PLAY_IRQ_IN);
  assign CAP_DMA_ALLOW_OUT = !(trd_q && int_q && CAP_IRQ_IN);
  assign CAL_BUSY_OUT = (cal_q != 8'h00);
  // R6 shared counts in legacy mode
  assign PLAY_COUNT_HI_OUT = ind_q[IND_PUB];
  assign PLAY_COUNT_LO_OUT = ind_q[IND_PLB];
  assign CAP_COUNT_HI_OUT = ext ? ind_q[IND_CUB] : ind_q[IND_PUB];
  assign CAP_COUNT_LO_OUT = ext ? ind_q[IND_CLB] : ind_q[IND_PLB];

  // R16 write clears interrupt
  a_int_clear: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // R16
    (WR_IN && ADDR_IN == OFS_STATUS && !CODEC_IRQ_SET_IN) |=> !int_q)
    else $error("interrupt not cleared by status write");
  // R14 busy index read
  a_busy_index: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // R14
    (busy && ADDR_IN == OFS_INDEX) |-> RDATA_OUT == BUSY_READ_VAL)
    else $error("index not 80h while busy");
  // R15 busy data port read
  a_busy_pio: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // R15
    (busy && ADDR_IN == OFS_PIO) |-> RDATA_OUT == BUSY_READ_VAL)
    else $error("data port not 80h while busy");
  // R22 extra writes ignored
  a_play_hold: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // R22
    (pio_wr && pfull_q) |=> $stable(pl_smp_q))
    else $error("playback byte taken past sample end");
  // R13 transfer disable stall
  a_trd_stall: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // R13
    (trd_q && int_q && PLAY_IRQ_IN) |-> !PLAY_DMA_ALLOW_OUT)
    else $error("playback DMA not stalled");
  // R25 calibration start
  a_cal_start: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // R25
    (mce_q && !mce_d && ind_q[IND_CFG][4:3] == 2'h3) |=> cal_q == CAL_LEN_FULL)
    else $error("full calibration length wrong");
  // R6 shared counts in legacy mode
  a_legacy_cnt: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // R6
    !ext |-> CAP_COUNT_LO_OUT == PLAY_COUNT_LO_OUT)
    else $error("legacy capture count not shared");
  // R1 rate/format protection
  a_fmt_lock: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // R1
    (win_wr && idx_q == IND_FMT && !mce_q) |=> ind_q[IND_FMT][3:0] == $past(ind_q[IND_FMT][3:0]))
    else $error("rate bits changed without mode change");
endmodule : achp_port
`default_nettype wire
